/* File: hw/wdfw_consts.svh */
// register offsets, field positions, reset values and timing counts
`ifndef WDFW_CONSTS_SVH
`define WDFW_CONSTS_SVH

`define WDFW_OFF_CFG 12'h000
`define WDFW_OFF_KEY 12'h004
`define WDFW_OFF_STAT 12'h008
`define WDFW_OFF_IST 12'h00c
`define WDFW_OFF_IMASK 12'h010

`define WDFW_CFG_EN 0
`define WDFW_CFG_SRC 1
`define WDFW_CFG_RATIO_LO 2
`define WDFW_CFG_RATIO_HI 3
`define WDFW_CFG_PAIRED 4
`define WDFW_CFG_FAST 5
`define WDFW_CFG_OSC_LO 6
`define WDFW_CFG_OSC_HI 7
`define WDFW_CFG_RST 8'h00

`define WDFW_KEY_OFF 4'ha

`define WDFW_IST_TIMEOUT 0
`define WDFW_IST_WAKE 1
`define WDFW_IST_OSCRDY 2

`define WDFW_OSC_CRYSTAL 2'h0
`define WDFW_DIV4_LAST 2'h3
`define WDFW_XTAL_CYCLES 11'h400
`define WDFW_RC_CYCLES 11'h002
`define WDFW_SUB_CYCLES 2'h2
`define WDFW_STARTUP_CYC 16

`endif

/* File: hw/wdfw_pkg.sv */
// types of the watchdog and fast wake-up block
package wdfw_pkg;
    typedef enum logic [1:0] {HALF_NONE, HALF_FIRST, HALF_SECOND} wdfw_half_t;
    typedef enum logic [2:0] {
        PWR_RUN, PWR_SLEEP, PWR_SUBWAIT, PWR_OSCWAIT, PWR_STARTUP
    } wdfw_pwr_t;
    typedef struct packed {
        logic [7:0] cfg;
        logic [3:0] key;
        logic [15:0] cnt;
        logic [1:0] div4;
        wdfw_half_t half;
        wdfw_pwr_t pwr;
        logic [15:0] wcnt;
        logic [10:0] ocnt;
        logic [1:0] scnt;
        logic sub_d;
        logic osc_d;
        logic wake_d;
        logic to_flag;
        logic pd_flag;
        logic rdy_flag;
        logic on_sub;
        logic [2:0] ist;
        logic [2:0] imask;
        logic [31:0] prdata;
        logic pslverr;
        logic dev_rst;
        logic pcsp_rst;
        logic wake_pulse;
    } wdfw_state_t;
endpackage

/* File: hw/wdfw_sync.sv */
// two-flop synchroniser for inputs from other domains
`timescale 1ns/1ps
module wdfw_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // data
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] ff1;
        logic [W-1:0] ff2;
    } wdfw_sync_t;

    wdfw_sync_t s_r;
    wdfw_sync_t s_nxt;

    always_comb begin
        s_nxt.ff1 = d;
        s_nxt.ff2 = s_r.ff1;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_r <= {RST_VAL, RST_VAL};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign q = s_r.ff2;
endmodule // wdfw_sync

/* File: hw/wdfw_top.sv */
// watchdog timer with fast wake-up control and apb registers
`timescale 1ns/1ps
`include "wdfw_consts.svh"
//
// Contract
// - source: sub clock or system clock over 4
// - watchdog disabled: clear instructions do nothing; halt still sleeps and sets the power-down flag
// - key 1010 alone stops the watchdog
// - key loads 1010 at power-on
// - timeout ratio 2^13 up to 2^16
// - clear resets only the final stage
// - sys/4 source stops in power-down
// - overflow running: device reset, timeout flag
// - overflow asleep: flag, reset pc and sp
// - count cleared: reset pin, clear, halt
// - single mode: one instruction clears
// - paired mode: halves must alternate to clear
// - fast wake-up needs enabled watchdog
// - crystal: sub clock, then 1024 cycles ready
// - rc oscillators wake within 1~2 cycles
// - halt clears; sys source stops count
// - power-down flag: halt sets, clear clears
// - start-up period after every wake-up
module wdfw_top
    import wdfw_pkg::*;
#(
    parameter int STARTUP_CYC = `WDFW_STARTUP_CYC
) (
    // apb slave
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // cpu core instructions, one-cycle strobes
    input wire logic instr_single_clear,
    input wire logic instr_first_half_clear,
    input wire logic instr_second_half_clear,
    input wire logic instr_halt,
    // pins and oscillators, asynchronous
    input wire logic sub_clock,
    input wire logic main_osc_clock,
    input wire logic external_reset_pin_n,
    input wire logic wake_pin,
    // reset and clock control
    output logic device_reset,
    output logic pc_sp_reset,
    output logic wake_done,
    output logic cpu_halted,
    output logic sys_clk_from_sub,
    output logic irq
);
    import wdfw_pkg::*;

    localparam logic [15:0] STARTUP_LAST = 16'(STARTUP_CYC - 1);

    wdfw_state_t s_r;
    wdfw_state_t s_nxt;

    logic sub_s;
    logic osc_s;
    logic rst_pin_n_s;
    logic wake_s;

    wdfw_sync #(.W(4), .RST_VAL(4'h2)) u_sync (
        .clk(pclk),
        .rst_n(presetn),
        .d({sub_clock, main_osc_clock, external_reset_pin_n, wake_pin}),
        .q({sub_s, osc_s, rst_pin_n_s, wake_s})
    );

    logic cfg_en;
    logic cfg_src_sys;
    logic [1:0] cfg_ratio;
    logic cfg_paired;
    logic cfg_fast;
    logic [1:0] cfg_osc;
    logic active;
    logic sub_rise;
    logic osc_rise;
    logic wake_rise;
    logic tick;
    logic [15:0] mask;
    logic [15:0] topbit;
    logic ovf;
    logic run;
    logic do_clear;
    logic do_halt;
    logic fast_path;
    logic [10:0] osc_target;
    logic setup;
    logic access;
    logic wr;
    logic [31:0] rd_val;
    logic rd_err;
    logic [2:0] ev;

    assign cfg_en = s_r.cfg[`WDFW_CFG_EN];
    assign cfg_src_sys = s_r.cfg[`WDFW_CFG_SRC];
    assign cfg_ratio = s_r.cfg[`WDFW_CFG_RATIO_HI:`WDFW_CFG_RATIO_LO];
    assign cfg_paired = s_r.cfg[`WDFW_CFG_PAIRED];
    assign cfg_fast = s_r.cfg[`WDFW_CFG_FAST];
    assign cfg_osc = s_r.cfg[`WDFW_CFG_OSC_HI:`WDFW_CFG_OSC_LO];

    assign active = cfg_en && (s_r.key != `WDFW_KEY_OFF);
    assign sub_rise = sub_s && !s_r.sub_d;
    assign osc_rise = osc_s && !s_r.osc_d;
    assign wake_rise = wake_s && !s_r.wake_d;
    assign run = (s_r.pwr == PWR_RUN);

    // sys/4 halts with the instruction clock outside run and start-up
    assign tick = cfg_src_sys ?
        (s_r.div4 == `WDFW_DIV4_LAST &&
         (run || s_r.pwr == PWR_STARTUP)) : sub_rise;

    // period mask: 13 to 16 bits
    assign mask = 16'hffff >> (2'h3 - cfg_ratio);
    assign topbit = mask ^ (mask >> 1);
    assign ovf = active && tick && ((s_r.cnt & mask) == mask);

    // valid software clear, decoded per scheme
    always_comb begin
        do_clear = 1'b0;
        if (cfg_en && run) begin
            if (!cfg_paired) begin
                do_clear = instr_single_clear;
            end else begin
                do_clear = (instr_first_half_clear &&
                            s_r.half == HALF_SECOND) ||
                           (instr_second_half_clear &&
                            s_r.half == HALF_FIRST);
            end
        end
    end

    assign do_halt = run && instr_halt;
    assign fast_path = cfg_fast && active &&
                       (cfg_osc == `WDFW_OSC_CRYSTAL);
    assign osc_target = (cfg_osc == `WDFW_OSC_CRYSTAL) ?
                        `WDFW_XTAL_CYCLES : `WDFW_RC_CYCLES;

    // apb decode; read data captured in the setup cycle
    assign setup = psel && !penable;
    assign access = psel && penable;
    assign wr = access && pwrite;

    always_comb begin
        rd_val = 32'h0;
        rd_err = 1'b0;
        unique case (paddr)
            `WDFW_OFF_CFG: rd_val = {24'h0, s_r.cfg};
            `WDFW_OFF_KEY: rd_val = {28'h0, s_r.key};
            `WDFW_OFF_STAT: rd_val = {24'h0, (s_r.pwr != PWR_RUN),
                s_r.on_sub, active, s_r.half, s_r.rdy_flag,
                s_r.pd_flag, s_r.to_flag};
            `WDFW_OFF_IST: rd_val = {29'h0, s_r.ist};
            `WDFW_OFF_IMASK: rd_val = {29'h0, s_r.imask};
            default: rd_err = 1'b1;
        endcase
    end

    always_comb begin
        s_nxt = s_r;
        ev = 3'h0;
        s_nxt.sub_d = sub_s;
        s_nxt.osc_d = osc_s;
        s_nxt.wake_d = wake_s;
        s_nxt.div4 = s_r.div4 + 2'h1;
        s_nxt.dev_rst = 1'b0;
        s_nxt.pcsp_rst = 1'b0;
        s_nxt.wake_pulse = 1'b0;

        if (setup) begin
            s_nxt.prdata = pwrite ? 32'h0 : rd_val;
            s_nxt.pslverr = rd_err;
        end
        if (wr && paddr == `WDFW_OFF_CFG) begin
            s_nxt.cfg = pwdata[7:0];
        end
        if (wr && paddr == `WDFW_OFF_KEY) begin
            s_nxt.key = pwdata[3:0];
        end
        if (wr && paddr == `WDFW_OFF_IMASK) begin
            s_nxt.imask = pwdata[2:0];
        end

        // watchdog counter
        if (active && tick) begin
            s_nxt.cnt = (s_r.cnt + 16'h1) & mask;
        end
        if (cfg_en && run && cfg_paired) begin
            if (instr_first_half_clear && s_r.half == HALF_NONE) begin
                s_nxt.half = HALF_FIRST;
            end
            if (instr_second_half_clear && s_r.half == HALF_NONE) begin
                s_nxt.half = HALF_SECOND;
            end
        end
        if (do_clear) begin
            s_nxt.cnt = s_r.cnt & ~topbit;
            s_nxt.half = HALF_NONE;
            s_nxt.pd_flag = 1'b0;
        end
        if (do_halt) begin
            if (cfg_en) begin
                s_nxt.cnt = 16'h0;
                s_nxt.half = HALF_NONE;
            end
            s_nxt.pd_flag = 1'b1;
            s_nxt.to_flag = 1'b0;
            s_nxt.rdy_flag = 1'b0;
            s_nxt.on_sub = 1'b0;
            s_nxt.pwr = PWR_SLEEP;
        end

        // crystal settling while already running from the sub clock
        if (s_r.on_sub && s_r.pwr != PWR_SLEEP && osc_rise) begin
            s_nxt.ocnt = s_r.ocnt + 11'h1;
            if (s_r.ocnt == `WDFW_XTAL_CYCLES - 11'h1) begin
                s_nxt.rdy_flag = 1'b1;
                s_nxt.on_sub = 1'b0;
                ev[`WDFW_IST_OSCRDY] = 1'b1;
            end
        end

        unique case (s_r.pwr)
            PWR_RUN: begin
            end
            PWR_SLEEP: begin
                if (wake_rise || ovf || !rst_pin_n_s) begin
                    s_nxt.ocnt = 11'h0;
                    s_nxt.scnt = 2'h0;
                    s_nxt.pwr = fast_path ? PWR_SUBWAIT : PWR_OSCWAIT;
                end
            end
            PWR_SUBWAIT: begin
                if (sub_rise) begin
                    s_nxt.scnt = s_r.scnt + 2'h1;
                    if (s_r.scnt == `WDFW_SUB_CYCLES - 2'h1) begin
                        s_nxt.on_sub = 1'b1;
                        s_nxt.wcnt = 16'h0;
                        s_nxt.pwr = PWR_STARTUP;
                    end
                end
            end
            PWR_OSCWAIT: begin
                if (osc_rise) begin
                    s_nxt.ocnt = s_r.ocnt + 11'h1;
                    if (s_r.ocnt == osc_target - 11'h1) begin
                        s_nxt.rdy_flag = 1'b1;
                        ev[`WDFW_IST_OSCRDY] = 1'b1;
                        s_nxt.wcnt = 16'h0;
                        s_nxt.pwr = PWR_STARTUP;
                    end
                end
            end
            PWR_STARTUP: begin
                s_nxt.wcnt = s_r.wcnt + 16'h1;
                if (s_r.wcnt == STARTUP_LAST) begin
                    s_nxt.wake_pulse = 1'b1;
                    ev[`WDFW_IST_WAKE] = 1'b1;
                    s_nxt.pwr = PWR_RUN;
                end
            end
        endcase

        if (ovf) begin
            s_nxt.cnt = 16'h0;
            s_nxt.half = HALF_NONE;
            s_nxt.to_flag = 1'b1;
            ev[`WDFW_IST_TIMEOUT] = 1'b1;
            if (s_r.pwr == PWR_SLEEP) begin
                s_nxt.pcsp_rst = 1'b1;
            end else begin
                s_nxt.dev_rst = 1'b1;
            end
        end
        if (!rst_pin_n_s) begin
            s_nxt.cnt = 16'h0;
            s_nxt.half = HALF_NONE;
        end

        // sticky events: set wins over write-one-to-clear
        if (wr && paddr == `WDFW_OFF_IST) begin
            s_nxt.ist = s_r.ist & ~pwdata[2:0];
        end
        s_nxt.ist = s_nxt.ist | ev;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r <= '0;
            s_r.cfg <= `WDFW_CFG_RST;
            s_r.key <= `WDFW_KEY_OFF;
            s_r.half <= HALF_NONE;
            s_r.pwr <= PWR_RUN;
            s_r.wake_d <= 1'b0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign prdata = s_r.prdata;
    assign pready = 1'b1;
    assign pslverr = access && s_r.pslverr;
    assign device_reset = s_r.dev_rst;
    assign pc_sp_reset = s_r.pcsp_rst;
    assign wake_done = s_r.wake_pulse;
    assign cpu_halted = (s_r.pwr != PWR_RUN);
    assign sys_clk_from_sub = s_r.on_sub;
    assign irq = |(s_r.ist & s_r.imask);

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_key_stops;
        (s_r.key == `WDFW_KEY_OFF) && tick |=> !s_r.dev_rst && !s_r.pcsp_rst;
    endproperty
    a_key_stops: assert property (p_key_stops)
        else $error("watchdog ran with key at the off value");

    property p_disabled_nop;
        !cfg_en && !rst_pin_n_s == 1'b0 && tick == 1'b0 &&
        instr_single_clear |=> $stable(s_r.cnt) && $stable(s_r.pd_flag);
    endproperty
    a_disabled_nop: assert property (p_disabled_nop)
        else $error("clear acted with watchdog disabled");

    property p_single_clear;
        run && cfg_en && !cfg_paired && instr_single_clear && !ovf
        |=> (s_r.cnt == ($past(s_r.cnt) & ~$past(topbit)) ||
             !$past(rst_pin_n_s)) && !s_r.pd_flag;
    endproperty
    a_single_clear: assert property (p_single_clear)
        else $error("single clear did not clear top stage");

    property p_repeat_half;
        run && cfg_en && cfg_paired && s_r.half == HALF_FIRST &&
        instr_first_half_clear && !instr_second_half_clear && !ovf &&
        rst_pin_n_s && !instr_halt |=> s_r.half == HALF_FIRST;
    endproperty
    a_repeat_half: assert property (p_repeat_half)
        else $error("repeated first half changed state");

    property p_ovf_run;
        ovf && run |=> s_r.dev_rst && s_r.to_flag && !s_r.pcsp_rst;
    endproperty
    a_ovf_run: assert property (p_ovf_run)
        else $error("overflow in run did not reset device");

    property p_ovf_sleep;
        ovf && s_r.pwr == PWR_SLEEP |=> s_r.pcsp_rst && !s_r.dev_rst &&
        s_r.to_flag;
    endproperty
    a_ovf_sleep: assert property (p_ovf_sleep)
        else $error("overflow asleep gave wrong reset");

    property p_halt_pdf;
        do_halt |=> s_r.pd_flag && !s_r.to_flag ##1 s_r.pwr != PWR_RUN;
    endproperty
    a_halt_pdf: assert property (p_halt_pdf)
        else $error("halt did not set power-down flag");

    property p_sys_stop;
        cfg_src_sys && s_r.pwr == PWR_SLEEP && rst_pin_n_s && !wake_rise
        |=> $stable(s_r.cnt);
    endproperty
    a_sys_stop: assert property (p_sys_stop)
        else $error("sys/4 watchdog counted in power-down");

    property p_xtal_ready;
        $rose(s_r.rdy_flag) && $past(s_r.on_sub) |->
        $past(s_r.ocnt) == `WDFW_XTAL_CYCLES - 11'h1 && !s_r.on_sub;
    endproperty
    a_xtal_ready: assert property (p_xtal_ready)
        else $error("crystal ready not after 1024 cycles");

    property p_startup;
        $rose(s_r.wake_pulse) |-> $past(s_r.pwr) == PWR_STARTUP &&
        $past(s_r.wcnt) == STARTUP_LAST;
    endproperty
    a_startup: assert property (p_startup)
        else $error("wake completed without start-up period");
endmodule // wdfw_top

/* File: tb/wdfw_cpu_model.sv */
// cpu core model issuing watchdog instructions
`timescale 1ns/1ps
module wdfw_cpu_model (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // core state
    input wire logic cpu_halted,
    // instruction strobes
    output logic single_clear,
    output logic first_half,
    output logic second_half,
    output logic halt
);
    initial begin
        single_clear = 1'h0;
        first_half = 1'h0;
        second_half = 1'h0;
        halt = 1'h0;
    end

    // 0 single, 1 first half, 2 second half, 3 halt; a halted core is idle
    task automatic issue(input int k);
        @(posedge pclk);
        while (cpu_halted !== 1'h0 || presetn !== 1'h1) @(posedge pclk);
        single_clear <= (k == 0);
        first_half <= (k == 1);
        second_half <= (k == 2);
        halt <= (k == 3);
        @(posedge pclk);
        single_clear <= 1'h0;
        first_half <= 1'h0;
        second_half <= 1'h0;
        halt <= 1'h0;
    endtask
endmodule // wdfw_cpu_model

/* File: tb/tb.sv */
// self-checking bench of the watchdog and fast wake-up block
`timescale 1ns/1ps
`include "wdfw_consts.svh"
module tb;
    logic pclk = 1'h0, presetn = 1'h0;
    logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic pready, pslverr, e, s_clr, h1, h2, hlt;
    logic sub_clock = 1'h0, main_osc_clock = 1'h0;
    logic ext_rst_n = 1'h1, wake_pin = 1'h0;
    logic device_reset, pc_sp_reset, wake_done, cpu_halted;
    logic sys_clk_from_sub, irq, saw_sub = 1'h0, saw_rst = 1'h0;
    int n_mismatch = 0, samples_checked = 0, n, k;
    int to_f, pd_f, rdy_f, half, act, ist;
    int seq[6] = '{0, 1, 1, 2, 2, 1};
    int eh[6] = '{0, 1, 1, 0, 2, 0};

    always #5 pclk = ~pclk;
    always #20 sub_clock = ~sub_clock;
    always #18.5 main_osc_clock = ~main_osc_clock;
    always @(posedge pclk) begin
        if (sys_clk_from_sub === 1'h1) saw_sub = 1'h1;
        if (device_reset === 1'h1) saw_rst = 1'h1;
    end

    wdfw_top #(.STARTUP_CYC(4)) u_dut (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .instr_single_clear(s_clr),
        .instr_first_half_clear(h1), .instr_second_half_clear(h2),
        .instr_halt(hlt), .sub_clock(sub_clock),
        .main_osc_clock(main_osc_clock), .external_reset_pin_n(ext_rst_n),
        .wake_pin(wake_pin), .device_reset(device_reset),
        .pc_sp_reset(pc_sp_reset), .wake_done(wake_done),
        .cpu_halted(cpu_halted), .sys_clk_from_sub(sys_clk_from_sub),
        .irq(irq));
    wdfw_cpu_model u_cpu (.pclk(pclk), .presetn(presetn),
        .cpu_halted(cpu_halted), .single_clear(s_clr), .first_half(h1),
        .second_half(h2), .halt(hlt));

    task automatic chk(input string nm, input logic [31:0] s,
                       input logic [31:0] x);
        samples_checked++;
        if (s !== x) begin
            n_mismatch++;
            $display("unexpected %s expected %h seen %h", nm, x, s);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        do @(posedge pclk); while (pready !== 1'h1);
        q = prdata;
        e = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask

    task automatic rd(input logic [11:0] a, input int x);
        apb(1'h0, a, 32'h0);
        chk("prdata", q, 32'(x));
    endtask

    function automatic int st();
        return to_f + 2 * pd_f + 4 * rdy_f + 8 * half + 32 * act;
    endfunction

    function automatic logic pick(input int sel);
        case (sel)
            0: pick = device_reset;
            1: pick = pc_sp_reset;
            2: pick = wake_done;
            3: pick = sys_clk_from_sub;
            default: pick = ~sys_clk_from_sub;
        endcase
    endfunction

    // bounded wait for an event, n holds the cycles taken
    task automatic wt(input int sel, input int lim);
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pick(sel) !== 1'h1 && n < lim);
        chk("event", {31'h0, pick(sel)}, 32'h1);
    endtask

    task automatic hl();
        u_cpu.issue(3);
        pd_f = 1;
        to_f = 0;
        rdy_f = 0;
        @(negedge pclk);
        chk("halted", {31'h0, cpu_halted}, 32'h1);
    endtask

    task automatic wk();
        @(posedge pclk);
        wake_pin <= 1'h1;
        repeat (4) @(posedge pclk);
        wake_pin <= 1'h0;
    endtask

    task automatic ck_irq();
        @(negedge pclk);
        chk("irq", {31'h0, irq}, 32'(ist != 0));
    endtask

    task automatic results();
        $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (90000) @(posedge pclk);
        n_mismatch++;
        results();
    end

    initial begin
        void'($urandom(75113));
        repeat (12) @(posedge pclk);
        presetn <= 1'h1;
        repeat (3) @(posedge pclk);
        rd(`WDFW_OFF_CFG, 0);
        rd(`WDFW_OFF_KEY, 10);
        rd(`WDFW_OFF_IMASK, 0);
        apb(1'h1, `WDFW_OFF_STAT, 32'hff);
        rd(`WDFW_OFF_STAT, 0);
        rd(12'h014, 0);
        chk("pslverr", {31'h0, e}, 32'h1);
        $display("test reset done");
        apb(1'h1, `WDFW_OFF_CFG, 32'h40);
        hl();
        wk();
        wt(2, 40);
        rdy_f = 1;
        ist = 6;
        u_cpu.issue(0);
        rd(`WDFW_OFF_STAT, st());
        rd(`WDFW_OFF_IST, ist);
        $display("test disabled done");
        k = $urandom % 16;
        if (k == 10) k = 5;
        apb(1'h1, `WDFW_OFF_KEY, 32'(k));
        rd(`WDFW_OFF_KEY, k);
        apb(1'h1, `WDFW_OFF_CFG, 32'h43);
        act = 1;
        u_cpu.issue(1);
        rd(`WDFW_OFF_STAT, st());
        u_cpu.issue(0);
        pd_f = 0;
        rd(`WDFW_OFF_STAT, st());
        apb(1'h1, `WDFW_OFF_CFG, 32'h53);
        for (int i = 0; i < 6; i++) begin
            u_cpu.issue(seq[i]);
            half = eh[i];
            rd(`WDFW_OFF_STAT, st());
        end
        $display("test clears done");
        apb(1'h1, `WDFW_OFF_CFG, 32'h43);
        apb(1'h1, `WDFW_OFF_IMASK, 32'h7);
        ck_irq();
        apb(1'h1, `WDFW_OFF_IST, 32'h6);
        ist = 0;
        ck_irq();
        @(posedge pclk);
        ext_rst_n <= 1'h0;
        repeat (5) @(posedge pclk);
        ext_rst_n <= 1'h1;
        wt(0, 34000);
        chk("period", 32'(n > 32600 && n < 32900), 32'h1);
        to_f = 1;
        ist = 1;
        ck_irq();
        rd(`WDFW_OFF_STAT, st());
        apb(1'h1, `WDFW_OFF_KEY, 32'ha);
        act = 0;
        apb(1'h1, `WDFW_OFF_IST, 32'h1);
        ist = 0;
        ck_irq();
        $display("test timeout done");
        apb(1'h1, `WDFW_OFF_KEY, 32'(k));
        act = 1;
        apb(1'h1, `WDFW_OFF_CFG, 32'h43);
        hl();
        repeat (40) @(posedge pclk);
        wk();
        wt(2, 40);
        rdy_f = 1;
        rd(`WDFW_OFF_STAT, st());
        apb(1'h1, `WDFW_OFF_CFG, 32'h41);
        saw_rst = 1'h0;
        hl();
        wt(1, 34000);
        chk("period", 32'(n > 32763 && n < 32771), 32'h1);
        wt(2, 60);
        to_f = 1;
        rdy_f = 1;
        ist = 7;
        rd(`WDFW_OFF_STAT, st());
        chk("reset", {31'h0, saw_rst}, 32'h0);
        rd(`WDFW_OFF_IST, ist);
        apb(1'h1, `WDFW_OFF_IST, 32'h7);
        ist = 0;
        $display("test sleep done");
        apb(1'h1, `WDFW_OFF_CFG, 32'h21);
        hl();
        wk();
        wt(3, 60);
        wt(2, 60);
        wt(4, 6000);
        rdy_f = 1;
        ist = 6;
        rd(`WDFW_OFF_STAT, st());
        apb(1'h1, `WDFW_OFF_KEY, 32'ha);
        act = 0;
        apb(1'h1, `WDFW_OFF_IST, 32'h6);
        ist = 0;
        saw_sub = 1'h0;
        hl();
        wk();
        wt(2, 6000);
        chk("sub", {31'h0, saw_sub}, 32'h0);
        rdy_f = 1;
        rd(`WDFW_OFF_STAT, st());
        $display("test fast wake done");
        results();
    end
endmodule // tb
